//--- rtl/aira_target.sv
/*
 * ADC register-access target: decodes the two-wire link, holds the pointer,
 * the result, setup and limit registers, and the general-call reset.
 * Assumes CLK much faster than SCL; SCL, SDA and strap come in asynchronously.
 */
`include "aira_defines.svh"
module aira_target #(
	parameter int RAW_W = 18,
	parameter int TMO_CYC = `AIRA_TMO_CYC
) (
	input wire logic CLK,
	input wire logic RST_B,
	aira_if.dev BUS,
	input wire logic [1:0] ADDR_SEL,
	input wire logic RES_VALID,
	input wire logic signed [RAW_W-1:0] RES_RAW,
	output aira_pkg::aira_word_t RESULT,
	output aira_pkg::aira_word_t SETUP,
	output aira_pkg::aira_word_t LOWER,
	output aira_pkg::aira_word_t UPPER,
	output logic PWR_DOWN
);
	import aira_pkg::*;
	localparam int TMO_W = $clog2(TMO_CYC + 1);

	// ============================================================
	// Helpers
	// Clip a wide signed code into 16-bit two's complement
	function automatic aira_word_t sat16(input logic signed [RAW_W-1:0] v);
		logic signed [RAW_W-1:0] hi;
		logic signed [RAW_W-1:0] lo;
		hi = RAW_W'(signed'(`AIRA_SAT_POS));
		lo = RAW_W'(signed'(`AIRA_SAT_NEG));
		if (v > hi) begin
			sat16 = `AIRA_SAT_POS;
		end else if (v < lo) begin
			sat16 = `AIRA_SAT_NEG;
		end else begin
			sat16 = v[15:0];
		end
	endfunction

	// ============================================================
	// Input synchronisers and edge detection
	logic [1:0] bus_s;
	logic [1:0] sel_s;
	logic scl_p_q;
	logic sda_p_q;
	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;

	aira_sync #(.W(2), .INIT(2'h3)) u_bus (
		.CLK(CLK),
		.RST_B(RST_B),
		.D({BUS.scl, BUS.sda}),
		.Q(bus_s)
	);
	aira_sync #(.W(2), .INIT(2'h0)) u_sel (
		.CLK(CLK),
		.RST_B(RST_B),
		.D(ADDR_SEL),
		.Q(sel_s)
	);

	// Edges of the synchronised lines
	assign scl_s = bus_s[1];
	assign sda_s = bus_s[0];
	assign scl_rise = scl_s & ~scl_p_q;
	assign scl_fall = ~scl_s & scl_p_q;
	assign start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;

	// ============================================================
	// State
	aira_dst_e st_q, st_d;
	aira_kind_e kind_q, kind_d;
	logic [7:0] sh_q, sh_d;
	logic [7:0] hi_q, hi_d;
	logic [3:0] bit_q, bit_d;
	logic [1:0] ptr_q, ptr_d;
	logic [1:0] strap_q, strap_d;
	logic rd_q, rd_d;
	logic half_q, half_d;
	logic oe_q, oe_d;
	logic pd_q, pd_d;
	logic [TMO_W-1:0] tmo_q, tmo_d;
	aira_word_t res_q, res_d;
	aira_word_t setup_q, setup_d;
	aira_word_t lower_q, lower_d;
	aira_word_t upper_q, upper_d;
	aira_word_t rdw;
	logic [7:0] txb;
	logic ack;

	// ============================================================
	// Next-state logic
	always_comb begin
		st_d = st_q;
		kind_d = kind_q;
		sh_d = sh_q;
		hi_d = hi_q;
		bit_d = bit_q;
		ptr_d = ptr_q;
		strap_d = strap_q;
		rd_d = rd_q;
		half_d = half_q;
		oe_d = oe_q;
		pd_d = pd_q;
		res_d = res_q;
		setup_d = setup_q;
		lower_d = lower_q;
		upper_d = upper_q;
		ack = 1'b0;
		// Register selected by the pointer, upper byte first
		case (ptr_q)
			`AIRA_PTR_RESULT: rdw = res_q;
			`AIRA_PTR_SETUP: rdw = setup_q;
			`AIRA_PTR_LOWER: rdw = lower_q;
			default: rdw = upper_q;
		endcase
		txb = half_q ? rdw[7:0] : rdw[15:8];
		// Latest clipped conversion; result stays at reset value until then
		if (RES_VALID) begin
			res_d = sat16(RES_RAW);
		end
		// Idle watchdog inside a transaction
		if (st_q == D_IDLE || scl_rise || scl_fall) begin
			tmo_d = '0;
		end else begin
			tmo_d = tmo_q + TMO_W'(1);
		end
		if (start_c) begin
			st_d = D_RX;
			kind_d = K_ADDR;
			bit_d = '0;
			oe_d = 1'b0;
			half_d = 1'b0;
			strap_d = sel_s;
		end else if (stop_c || tmo_q == TMO_W'(TMO_CYC - 1)) begin
			st_d = D_IDLE;
			oe_d = 1'b0;
		end else begin
			case (st_q)
				D_RX: begin
					if (scl_rise) begin
						sh_d = {sh_q[6:0], sda_s};
						bit_d = bit_q + 4'h1;
					end else if (scl_fall && bit_q == `AIRA_BIT_LAST) begin
						ack = 1'b1;
						case (kind_q)
							K_ADDR: begin
								if (sh_q[7:1] == (`AIRA_ADDR_BASE | {5'h00, strap_q})) begin
									rd_d = sh_q[0];
									kind_d = K_PTR;
								end else if (sh_q == `AIRA_GC_ADDR) begin
									kind_d = K_GC;
								end else begin
									ack = 1'b0;
								end
							end
							K_PTR: begin
								ptr_d = sh_q[1:0];
								kind_d = K_DHI;
							end
							K_DHI: begin
								hi_d = sh_q;
								kind_d = K_DLO;
							end
							K_DLO: begin
								kind_d = K_DHI;
								case (ptr_q)
									`AIRA_PTR_SETUP: begin
										setup_d = {hi_q, sh_q};
										pd_d = 1'b0;
									end
									`AIRA_PTR_LOWER: lower_d = {hi_q, sh_q};
									`AIRA_PTR_UPPER: upper_d = {hi_q, sh_q};
									default: ;
								endcase
							end
							K_GC: begin
								kind_d = K_SKIP;
								if (sh_q == `AIRA_GC_RESET) begin
									ptr_d = `AIRA_PTR_RESULT;
									res_d = `AIRA_RESULT_RST;
									setup_d = `AIRA_SETUP_RST;
									lower_d = `AIRA_LOWER_RST;
									upper_d = `AIRA_UPPER_RST;
									pd_d = 1'b1;
								end
							end
							default: ;
						endcase
						oe_d = ack;
						st_d = ack ? D_RXACK : D_IDLE;
					end
				end
				D_RXACK: begin
					if (scl_fall) begin
						bit_d = '0;
						if (rd_q && kind_q == K_PTR) begin
							sh_d = txb;
							oe_d = ~txb[7];
							half_d = ~half_q;
							st_d = D_TX;
						end else begin
							oe_d = 1'b0;
							st_d = D_RX;
						end
					end
				end
				D_TX: begin
					if (scl_fall) begin
						sh_d = {sh_q[6:0], 1'b0};
						bit_d = bit_q + 4'h1;
						if (bit_q == 4'h7) begin
							oe_d = 1'b0;
							st_d = D_TXACK;
						end else begin
							oe_d = ~sh_q[6];
						end
					end
				end
				D_TXACK: begin
					if (scl_rise) begin
						st_d = sda_s ? D_IDLE : D_TXLD;
					end
				end
				D_TXLD: begin
					if (scl_fall) begin
						sh_d = txb;
						oe_d = ~txb[7];
						half_d = ~half_q;
						bit_d = '0;
						st_d = D_TX;
					end
				end
				default: st_d = D_IDLE;
			endcase
		end
	end

	// ============================================================
	// Registers
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			st_q <= D_IDLE;
			kind_q <= K_ADDR;
			sh_q <= 8'h00;
			hi_q <= 8'h00;
			bit_q <= 4'h0;
			ptr_q <= `AIRA_PTR_RESULT;
			strap_q <= 2'h0;
			rd_q <= 1'b0;
			half_q <= 1'b0;
			oe_q <= 1'b0;
			pd_q <= 1'b1;
			tmo_q <= '0;
			res_q <= `AIRA_RESULT_RST;
			setup_q <= `AIRA_SETUP_RST;
			lower_q <= `AIRA_LOWER_RST;
			upper_q <= `AIRA_UPPER_RST;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			st_q <= st_d;
			kind_q <= kind_d;
			sh_q <= sh_d;
			hi_q <= hi_d;
			bit_q <= bit_d;
			ptr_q <= ptr_d;
			strap_q <= strap_d;
			rd_q <= rd_d;
			half_q <= half_d;
			oe_q <= oe_d;
			pd_q <= pd_d;
			tmo_q <= tmo_d;
			res_q <= res_d;
			setup_q <= setup_d;
			lower_q <= lower_d;
			upper_q <= upper_d;
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	// Outputs straight from flops
	assign BUS.sda_oe_dev = oe_q;
	assign RESULT = res_q;
	assign SETUP = setup_q;
	assign LOWER = lower_q;
	assign UPPER = upper_q;
	assign PWR_DOWN = pd_q;
endmodule

//--- rtl/aira_defines.svh
/*
 * Constants of the register-access link of the ADC: addresses, codes,
 * reset values and timing counts. Included by the target and the controller.
 */
// Functional notes
// - Acknowledge general-call address with write bit
// - General-call byte 06h resets registers, powers down
// - First written byte after address loads pointer
// - After pointer, STOP, repeated START or data
// - Read: pointer write frame, then read frame
// - Release SDA on NACK, START or STOP
// - Pointer kept across transactions until rewritten
// - Config write: pointer plus two bytes, all acknowledged
// - Results saturate at 7FFFh and 8000h
// - One step is 0001h, zero 0000h, minus FFFFh
// - Pointer bits 1:0 select register, upper zero
// - Result register reads 0000h until first conversion
// - Result holds latest conversion, writes ignored
// - Setup register resets to 8583h
// - Lower and upper limit registers writable via pointer
// - Target address 1001000b plus two strap bits
// - Bytes MSB first, receiver acknowledges each; the controller NACKs the last byte it reads
// - Idle 25 ms resets interface; host restarts with START
`ifndef AIRA_DEFINES_SVH
`define AIRA_DEFINES_SVH
// ============================================================
// Bus codes
`define AIRA_ADDR_BASE 7'h48
`define AIRA_GC_ADDR 8'h00
`define AIRA_GC_RESET 8'h06
`define AIRA_BIT_LAST 4'h8
// ============================================================
// Pointer values
`define AIRA_PTR_RESULT 2'h0
`define AIRA_PTR_SETUP 2'h1
`define AIRA_PTR_LOWER 2'h2
`define AIRA_PTR_UPPER 2'h3
// ============================================================
// Reset and clip values
`define AIRA_RESULT_RST 16'h0000
`define AIRA_SETUP_RST 16'h8583
`define AIRA_LOWER_RST 16'h8000
`define AIRA_UPPER_RST 16'h7FFF
`define AIRA_SAT_POS 16'h7FFF
`define AIRA_SAT_NEG 16'h8000
// ============================================================
// Timing
`define AIRA_CLK_KHZ 20000
`define AIRA_TMO_MS 25
`define AIRA_TMO_CYC (`AIRA_TMO_MS * `AIRA_CLK_KHZ)
`define AIRA_SCL_KHZ 100
`define AIRA_QTR_CYC (`AIRA_CLK_KHZ / (4 * `AIRA_SCL_KHZ))
// ============================================================
// Controller command port
`define AIRA_HR_CMD 2'h0
`define AIRA_HR_DATA 2'h1
`define AIRA_HR_STAT 2'h2
`define AIRA_HR_TGT 2'h3
`define AIRA_CMD_RD 2
`define AIRA_CMD_GC 3
`endif

//--- rtl/aira_pkg.sv
/*
 * Types used by the two ends of the link.
 * Assumes nothing beyond the defines header.
 */
package aira_pkg;
	typedef logic [15:0] aira_word_t;
	typedef enum logic [2:0] {D_IDLE = 3'h0, D_RX = 3'h1, D_RXACK = 3'h2, D_TX = 3'h3,
		D_TXACK = 3'h4, D_TXLD = 3'h5} aira_dst_e;
	typedef enum logic [2:0] {K_ADDR = 3'h0, K_PTR = 3'h1, K_DHI = 3'h2, K_DLO = 3'h3,
		K_GC = 3'h4, K_SKIP = 3'h5} aira_kind_e;
	typedef enum logic [1:0] {C_WR = 2'h0, C_RD = 2'h1, C_GC = 2'h2} aira_cmd_e;
	typedef enum logic [2:0] {O_ST = 3'h0, O_TX = 3'h1, O_RXA = 3'h2, O_RXN = 3'h3,
		O_SP = 3'h4} aira_op_e;
endpackage

//--- rtl/aira_if.sv
/*
 * Two-wire open-drain link between controller and ADC target.
 * Pull-ups are modelled: a line is high unless some enable pulls it low.
 */
interface aira_if;
	logic scl_oe_host;
	logic sda_oe_host;
	logic sda_oe_dev;
	logic scl;
	logic sda;
	// Wired-AND of the open-drain drivers
	assign scl = ~scl_oe_host;
	assign sda = ~(sda_oe_host | sda_oe_dev);
	modport dev (input scl, input sda, output sda_oe_dev);
	modport host (input scl, input sda, output scl_oe_host, output sda_oe_host);
endinterface

//--- rtl/aira_sync.sv
/*
 * Two-flop synchroniser for levels from outside the clock domain.
 * Assumes CLK free running and RST_B asynchronous active low.
 */
module aira_sync #(
	parameter int W = 2,
	parameter logic [W-1:0] INIT = '1
) (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic [W-1:0] D,
	output logic [W-1:0] Q
);
	logic [W-1:0] meta_q;
	// ============================================================
	// First stage feeds only the second
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			meta_q <= INIT;
			Q <= INIT;
		end else begin
			meta_q <= D;
			Q <= meta_q;
		end
	end
endmodule

//--- rtl/aira_ctrl.sv
/*
 * Link controller: drives SCL by dividing CLK and runs write, read and
 * general-call frames ordered through a small register port.
 * Assumes the target answers within one SCL quarter of each edge.
 */
`include "aira_defines.svh"
module aira_ctrl #(
	parameter int QTR = `AIRA_QTR_CYC
) (
	input wire logic CLK,
	input wire logic RST_B,
	aira_if.host BUS,
	input wire logic [1:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output aira_pkg::aira_word_t RDATA
);
	import aira_pkg::*;

	// ============================================================
	// Frame tables
	function automatic aira_op_e op_of(input aira_cmd_e k, input logic [3:0] s);
		case (k)
			C_WR: op_of = (s == 4'h0) ? O_ST : (s == 4'h5) ? O_SP : O_TX;
			C_RD: begin
				case (s)
					4'h0, 4'h3: op_of = O_ST;
					4'h5: op_of = O_RXA;
					4'h6: op_of = O_RXN;
					4'h7: op_of = O_SP;
					default: op_of = O_TX;
				endcase
			end
			default: op_of = (s == 4'h0) ? O_ST : (s == 4'h3) ? O_SP : O_TX;
		endcase
	endfunction

	function automatic logic [7:0] byte_of(input aira_cmd_e k, input logic [3:0] s,
		input logic [6:0] t, input logic [1:0] p, input aira_word_t d);
		case (k)
			C_GC: byte_of = (s == 4'h1) ? `AIRA_GC_ADDR : `AIRA_GC_RESET;
			C_RD: byte_of = (s == 4'h4) ? {t, 1'b1} : (s == 4'h1) ? {t, 1'b0} : {6'h00, p};
			default: begin
				case (s)
					4'h1: byte_of = {t, 1'b0};
					4'h2: byte_of = {6'h00, p};
					4'h3: byte_of = d[15:8];
					default: byte_of = d[7:0];
				endcase
			end
		endcase
	endfunction

	// ============================================================
	// SDA synchroniser
	logic [0:0] sda_s;
	aira_sync #(.W(1), .INIT(1'h1)) u_sda (
		.CLK(CLK),
		.RST_B(RST_B),
		.D(BUS.sda),
		.Q(sda_s)
	);

	// ============================================================
	// State
	logic busy_q, busy_d;
	logic nack_q, nack_d;
	logic abort_q, abort_d;
	aira_cmd_e cmd_q, cmd_d;
	logic [1:0] ptr_q, ptr_d;
	logic [6:0] tgt_q, tgt_d;
	aira_word_t data_q, data_d;
	aira_word_t rdata_q, rdata_d;
	logic [3:0] step_q, step_d;
	logic [3:0] bitn_q, bitn_d;
	logic [1:0] qp_q, qp_d;
	logic [7:0] div_q, div_d;
	logic [7:0] rx_q, rx_d;
	logic scl_oe_q, scl_oe_d;
	logic sda_oe_q, sda_oe_d;
	aira_op_e op;
	logic [7:0] txb;
	logic last;

	// ============================================================
	// Next-state logic
	always_comb begin
		busy_d = busy_q;
		nack_d = nack_q;
		abort_d = abort_q;
		cmd_d = cmd_q;
		ptr_d = ptr_q;
		tgt_d = tgt_q;
		data_d = data_q;
		step_d = step_q;
		bitn_d = bitn_q;
		qp_d = qp_q;
		div_d = div_q;
		rx_d = rx_q;
		scl_oe_d = scl_oe_q;
		sda_oe_d = sda_oe_q;
		op = abort_q ? O_SP : op_of(cmd_q, step_q);
		txb = byte_of(cmd_q, step_q, tgt_q, ptr_q, data_q);
		last = (qp_q == 2'h3);
		// Command port read, one cycle later
		case (ADDR)
			`AIRA_HR_CMD: rdata_d = {13'h0000, cmd_q == C_RD, ptr_q};
			`AIRA_HR_DATA: rdata_d = data_q;
			`AIRA_HR_STAT: rdata_d = {14'h0000, nack_q, busy_q};
			default: rdata_d = {9'h000, tgt_q};
		endcase
		if (!RD) begin
			rdata_d = 16'h0000;
		end
		// Command port write; frames start only when idle
		if (WR && !busy_q) begin
			case (ADDR)
				`AIRA_HR_CMD: begin
					ptr_d = WDATA[1:0];
					cmd_d = WDATA[`AIRA_CMD_GC] ? C_GC : WDATA[`AIRA_CMD_RD] ? C_RD : C_WR;
					busy_d = 1'b1;
					nack_d = 1'b0;
					abort_d = 1'b0;
					step_d = 4'h0;
					bitn_d = 4'h0;
					qp_d = 2'h0;
					div_d = 8'h00;
				end
				`AIRA_HR_DATA: data_d = WDATA;
				`AIRA_HR_TGT: tgt_d = WDATA[6:0];
				default: ;
			endcase
		end
		// Quarter-period engine
		if (busy_q) begin
			if (div_q == 8'(QTR - 1)) begin
				div_d = 8'h00;
				qp_d = qp_q + 2'h1;
				scl_oe_d = (qp_q == 2'h0) || (last && op != O_SP);
				case (op)
					O_ST: begin
						if (qp_q == 2'h0) begin
							sda_oe_d = 1'b0;
						end else if (qp_q == 2'h2) begin
							sda_oe_d = 1'b1;
						end
						if (last) begin
							step_d = step_q + 4'h1;
						end
					end
					O_SP: begin
						if (qp_q == 2'h0) begin
							sda_oe_d = 1'b1;
						end else if (qp_q == 2'h2) begin
							sda_oe_d = 1'b0;
						end
						if (last) begin
							busy_d = 1'b0;
						end
					end
					default: begin
						if (qp_q == 2'h0) begin
							if (bitn_q == `AIRA_BIT_LAST) begin
								sda_oe_d = (op == O_RXA);
							end else begin
								sda_oe_d = (op == O_TX) && !txb[3'h7 - bitn_q[2:0]];
							end
						end else if (qp_q == 2'h2) begin
							if (bitn_q != `AIRA_BIT_LAST) begin
								rx_d = {rx_q[6:0], sda_s[0]};
							end else if (op == O_TX && sda_s[0]) begin
								nack_d = 1'b1;
							end
						end else if (last) begin
							bitn_d = bitn_q + 4'h1;
							if (bitn_q == `AIRA_BIT_LAST) begin
								bitn_d = 4'h0;
								step_d = step_q + 4'h1;
								// Refused byte: SCL is low again, so a full STOP can follow
								abort_d = nack_q;
								if (op == O_RXA) begin
									data_d[15:8] = rx_q;
								end else if (op == O_RXN) begin
									data_d[7:0] = rx_q;
								end
							end
						end
					end
				endcase
			end else begin
				div_d = div_q + 8'h01;
			end
		end
	end

	// ============================================================
	// Registers
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			busy_q <= 1'b0;
			nack_q <= 1'b0;
			abort_q <= 1'b0;
			cmd_q <= C_WR;
			ptr_q <= `AIRA_PTR_RESULT;
			tgt_q <= `AIRA_ADDR_BASE;
			data_q <= 16'h0000;
			rdata_q <= 16'h0000;
			step_q <= 4'h0;
			bitn_q <= 4'h0;
			qp_q <= 2'h0;
			div_q <= 8'h00;
			rx_q <= 8'h00;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else begin
			busy_q <= busy_d;
			nack_q <= nack_d;
			abort_q <= abort_d;
			cmd_q <= cmd_d;
			ptr_q <= ptr_d;
			tgt_q <= tgt_d;
			data_q <= data_d;
			rdata_q <= rdata_d;
			step_q <= step_d;
			bitn_q <= bitn_d;
			qp_q <= qp_d;
			div_q <= div_d;
			rx_q <= rx_d;
			scl_oe_q <= scl_oe_d;
			sda_oe_q <= sda_oe_d;
		end
	end

	assign BUS.scl_oe_host = scl_oe_q;
	assign BUS.sda_oe_host = sda_oe_q;
	assign RDATA = rdata_q;
endmodule

//--- sim/aira_monitor.sv
/*
 * Link checker: timing and acknowledge properties on the two-wire link.
 * Assumes it sees the interface lines and the CLK domain of both ends.
 */
module aira_monitor (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic scl_oe_host,
	input wire logic sda_oe_host,
	input wire logic sda_oe_dev,
	input wire logic scl,
	input wire logic sda
);
	// ============================================================
	// Bit tracking
	logic scl_q, sda_q, first_q, first_d, rd_q, rd_d, rise, fall, start, stop;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] sr_q, sr_d;
	// Line edges and bus conditions
	assign rise = scl & ~scl_q;
	assign fall = ~scl & scl_q;
	assign start = scl & scl_q & sda_q & ~sda;
	assign stop = scl & scl_q & ~sda_q & sda;
	// Bit slot, shifted byte, first byte and direction of the frame
	always_comb begin
		cnt_d = cnt_q;
		sr_d = sr_q;
		first_d = first_q;
		rd_d = rd_q;
		if (start) begin
			// The SCL fall that closes START opens bit 0, so start one below it
			cnt_d = 4'hF;
			first_d = 1'b1;
			rd_d = 1'b0;
		end else if (fall) begin
			cnt_d = (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
			first_d = (cnt_q == 4'h8) ? 1'b0 : first_q;
		end
		if (rise && cnt_q < 4'h8) begin
			sr_d = {sr_q[6:0], sda};
		end
		if (rise && cnt_q == 4'h8 && first_q) begin
			rd_d = sr_q[0];
		end
	end
	// Registers of the tracker
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			cnt_q <= 4'h0;
			sr_q <= 8'h00;
			first_q <= 1'b0;
			rd_q <= 1'b0;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			cnt_q <= cnt_d;
			sr_q <= sr_d;
			first_q <= first_d;
			rd_q <= rd_d;
		end
	end
	// ============================================================
	// Properties
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_B);
	property p_ack_low; $rose(sda_oe_dev) |-> !scl; endproperty
	property p_scl_high; rise |-> scl [*8]; endproperty
	property p_stop_idle; stop |=> (scl && sda) [*8]; endproperty
	property p_gc_ack; rise && cnt_q == 4'h8 && first_q && sr_q == 8'h00 |-> !sda; endproperty
	property p_nack; rise && cnt_q == 4'h8 && first_q && sr_q[7:3] != 5'h12 && sr_q != 8'h00 |-> sda; endproperty
	property p_ack_hold; rise && cnt_q == 4'h8 && !sda |-> !sda [*8]; endproperty
	property p_rd_release; rise && cnt_q == 4'h8 && !first_q && rd_q |-> !sda_oe_dev; endproperty
	property p_wr_ack; rise && cnt_q == 4'h8 && !first_q && !rd_q |-> sda_oe_dev; endproperty
	property p_host_quiet; fall && cnt_q < 4'h8 && !first_q && rd_q |-> !sda_oe_host; endproperty
	a_ack_low: assert property (p_ack_low) else $error("target changed data with clock high");
	a_scl_high: assert property (p_scl_high) else $error("clock high phase too short");
	a_stop_idle: assert property (p_stop_idle) else $error("bus not idle after stop");
	a_gc_ack: assert property (p_gc_ack) else $error("general call not acknowledged");
	a_nack: assert property (p_nack) else $error("foreign address acknowledged");
	a_ack_hold: assert property (p_ack_hold) else $error("acknowledge not held");
	a_rd_release: assert property (p_rd_release) else $error("target drives in host ack slot");
	a_wr_ack: assert property (p_wr_ack) else $error("written byte not acknowledged");
	a_host_quiet: assert property (p_host_quiet) else $error("host drives during target data bit");
	cover property (rise && cnt_q == 4'h8 && first_q && sr_q == 8'h00);
	cover property (rise && cnt_q == 4'h8 && first_q && sr_q[0]);
	cover property (rise && cnt_q == 4'h8 && first_q && sda);
	cover property (stop ##1 !scl_oe_host);
endmodule

//--- sim/tb_adc_i2c_register_access.sv
/*
 * Testbench: both link ends joined, driven through the command port.
 * Assumes the design files and the link checker are compiled first.
 */
module tb_adc_i2c_register_access;
	timeunit 1ns;
	timeprecision 1ns;
	import aira_pkg::*;
	// ============================================================
	// Signals and tables
	logic clk, rst_b, wr, rd, res_valid, pwr_down, n;
	logic [1:0] addr, addr_sel;
	logic [15:0] wdata, q;
	logic signed [17:0] res_raw;
	aira_word_t rdata, result, setup, lower, upper;
	int fails, samples_checked, cyc;
	logic [15:0] v [4] = '{16'h0000, 16'h4A1C, 16'hFF01, 16'h00FE};
	logic [17:0] raw_t [6] = '{18'h0_8000, 18'h0_7FFF, 18'h0_0001, 18'h0_0000, 18'h3_FFFF, 18'h3_7FFF};
	logic [15:0] exp_t [6] = '{16'h7FFF, 16'h7FFF, 16'h0001, 16'h0000, 16'hFFFF, 16'h8000};
	// ============================================================
	// Both ends and the checker
	aira_if aira_if_i ();
	aira_ctrl #(.QTR(5)) aira_ctrl_i (.CLK(clk), .RST_B(rst_b), .BUS(aira_if_i.host), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata));
	aira_target #(.TMO_CYC(2000)) aira_target_i (.CLK(clk), .RST_B(rst_b), .BUS(aira_if_i.dev),
		.ADDR_SEL(addr_sel), .RES_VALID(res_valid), .RES_RAW(res_raw), .RESULT(result), .SETUP(setup),
		.LOWER(lower), .UPPER(upper), .PWR_DOWN(pwr_down));
	aira_monitor aira_monitor_i (.CLK(clk), .RST_B(rst_b), .scl_oe_host(aira_if_i.scl_oe_host),
		.sda_oe_host(aira_if_i.sda_oe_host), .sda_oe_dev(aira_if_i.sda_oe_dev), .scl(aira_if_i.scl),
		.sda(aira_if_i.sda));
	// Clock and hang limit
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			fails++;
			finish_test();
		end
	end
	// ============================================================
	// Tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t ns: saw %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [1:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	// One frame: data word, command, poll until idle, fetch the word
	task automatic xfer(input logic [3:0] c, input logic [15:0] d, output logic [15:0] r, output logic nk);
		logic [15:0] s;
		wr_reg(2'h1, d);
		wr_reg(2'h0, {12'h000, c});
		s = 16'h0001;
		for (int k = 0; k < 4000 && s[0] !== 1'b0; k++) begin
			rd_reg(2'h2, s);
		end
		chk({15'h0000, s[0]}, 16'h0000);
		nk = s[1];
		rd_reg(2'h1, r);
	endtask
	task automatic finish_test;
		$display("compares %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// ============================================================
	// Main sequence
	initial begin
		rst_b = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 2'h0;
		wdata = 16'h0000;
		addr_sel = 2'h0;
		res_valid = 1'b0;
		res_raw = '0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk(result, 16'h0000);
		chk(setup, 16'h8583);
		// Link reads of the untouched result and setup registers
		xfer(4'h4, 16'h0000, q, n);
		chk({15'h0000, n}, 16'h0000);
		chk(q, 16'h0000);
		xfer(4'h5, 16'h0000, q, n);
		chk(q, 16'h8583);
		// Write each writable register, then read it back
		for (int i = 1; i < 4; i++) begin
			xfer({2'b00, i[1:0]}, v[i], q, n);
			chk({15'h0000, n}, 16'h0000);
			xfer({2'b01, i[1:0]}, 16'h0000, q, n);
			chk(q, v[i]);
		end
		chk(setup, v[1]);
		chk(lower, v[2]);
		chk(upper, v[3]);
		// A write aimed at the result is acknowledged and dropped
		xfer(4'h0, 16'hBEEF, q, n);
		chk({15'h0000, n}, 16'h0000);
		chk(result, 16'h0000);
		// Conversion codes, clipped at both ends
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			res_raw <= raw_t[i];
			res_valid <= 1'b1;
			@(posedge clk);
			res_valid <= 1'b0;
			@(posedge clk);
			#1;
			chk(result, exp_t[i]);
		end
		xfer(4'h4, 16'h0000, q, n);
		chk(q, 16'h8000);
		// Each strap code answers its own address
		for (int s = 0; s < 4; s++) begin
			@(posedge clk);
			addr_sel <= s[1:0];
			wr_reg(2'h3, 16'h0048 + {14'h0000, s[1:0]});
			xfer(4'h5, 16'h0000, q, n);
			chk({15'h0000, n}, 16'h0000);
			chk(q, v[1]);
		end
		// Foreign addresses are refused
		for (int t = 0; t < 2; t++) begin
			wr_reg(2'h3, (t == 0) ? 16'h0049 : 16'h0050);
			xfer(4'h5, 16'h0000, q, n);
			chk({15'h0000, n}, 16'h0001);
		end
		// General call reset
		xfer(4'h8, 16'h0006, q, n);
		chk({15'h0000, n}, 16'h0000);
		chk(setup, 16'h8583);
		chk(lower, 16'h8000);
		chk(upper, 16'h7FFF);
		chk({15'h0000, pwr_down}, 16'h0001);
		finish_test();
	end
endmodule
